// file: bench/subtract_swap_xor_sleep_exec_tb_top.sv
// Self-checking bench for the execution unit, driven over AHB-Lite
`timescale 1ns/1ps
module subtract_swap_xor_sleep_exec_tb_top;
  import exec_pkg::*;
  localparam int LIMIT = 20000;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        wake_req;
  dir_type     dir_out;
  logic        sleeping;
  logic [31:0] rd;
  int          miscompares;
  int          tests_run;
  int          cyc = 0;

  // Prescaler shortened so the watchdog moves within a short run
  exec_unit #(.ADDR_W(12), .PRESC_W(2)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .wake_req(wake_req), .dir_out(dir_out), .sleeping(sleeping)
  );

  // Free-running 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask

  // Sample ready in the settled half-cycle, then act after the edge it decides; only the hang guard ends a wait
  task automatic wait_ready(output logic [31:0] data);
    logic ok;
    ok = 1'b0;
    while (ok !== 1'b1) begin
      @(negedge hclk);
      ok = hreadyout;
      data = hrdata;
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    logic [31:0] dummy;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_ready(dummy);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0000_0000;
    wait_ready(q);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] cmd(op_type op, logic [7:0] opnd, logic dest);
    return {15'h0000, dest, opnd, 5'h00, op};
  endfunction

  // One operation on file cell 127 with preset W and flags; result and flags judged
  task automatic t_op(op_type op, logic [7:0] f, logic [7:0] w, logic [2:0] pre, logic dest);
    logic [8:0] full;
    logic [4:0] half;
    logic       cin;
    logic [7:0] res;
    logic [2:0] fl;
    logic       lit;
    lit  = (op == OP_SUBLIT) || (op == OP_XORLIT);
    cin  = (op == OP_SUBBORROW) ? pre[0] : 1'b1;
    full = {1'b0, f} + {1'b0, ~w} + 9'(cin);
    half = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'(cin);
    res  = full[7:0];
    fl   = {(res == 8'h00), half[4], full[8]};
    if (op == OP_SWAP) begin
      res = {f[3:0], f[7:4]};
      fl  = pre;
    end else if (op == OP_XORLIT || op == OP_XORFILE) begin
      res = f ^ w;
      fl  = {(res == 8'h00), pre[1:0]};
    end
    wr(OFS_FILE_BASE + 12'h1FC, {24'h000000, f});
    wr(OFS_WORK, {24'h000000, w});
    wr(OFS_STATUS, {29'h00000000, pre});
    wr(OFS_CMD, cmd(op, lit ? f : 8'h7F, dest));
    rdc(OFS_STATUS, {27'h0000000, 2'b11, fl});
    rdc(OFS_WORK, {24'h000000, (dest && !lit) ? w : res});
    rdc(OFS_FILE_BASE + 12'h1FC, {24'h000000, (dest && !lit) ? res : f});
    $display("Test op %0d done", op);
  endtask

  // Direction load for every port select and two illegal selects (4 and 8)
  task automatic t_dir();
    logic [23:0] ed;
    ed = 24'hFFFFFF;
    chk_pin(dir_out, ed);
    for (int s = 4; s <= 8; s++) begin
      wr(OFS_STATUS, 32'h0000_0005);
      wr(OFS_WORK, 32'h0000_0030 + s);
      wr(OFS_CMD, cmd(OP_DIR, 8'(s), 1'b0));
      if (s >= 5 && s <= 7) ed[(s-5)*8 +: 8] = 8'h30 + 8'(s);
      rdc(OFS_DIR, {8'h00, ed});
      chk_pin(dir_out, ed);
      rdc(OFS_STATUS, 32'h0000_001D);
    end
    $display("Test direction load done");
  endtask

  // Sleep: watchdog cleared, expiry flag set and power-down flag cleared, halted, commands ignored, then woken
  task automatic t_sleep();
    wr(OFS_WORK, 32'h0000_0012);
    wr(OFS_STATUS, 32'h0000_0000);
    repeat (20) @(posedge hclk);
    wr(OFS_CMD, cmd(OP_SLEEP, 8'h00, 1'b0));
    rdc(OFS_WATCHDOG, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0030);
    chk_pin({23'h000000, sleeping}, 24'h000001);
    wr(OFS_CMD, cmd(OP_XORLIT, 8'hFF, 1'b0));
    rdc(OFS_CMD, cmd(OP_SLEEP, 8'h00, 1'b0));
    rdc(OFS_WORK, 32'h0000_0012);
    rdc(OFS_WATCHDOG, 32'h0000_0000);
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    repeat (3) @(posedge hclk);
    chk_pin({23'h000000, sleeping}, 24'h000000);
    wr(OFS_CMD, cmd(OP_XORLIT, 8'hFF, 1'b0));
    rdc(OFS_WORK, 32'h0000_00ED);
    $display("Test sleep done");
  endtask

  // Reset release and the values left by reset
  task automatic t_reset();
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_STATUS, 32'h0000_0018);
    rdc(OFS_WORK, 32'h0000_0000);
    rdc(12'h100, 32'h0000_0000);
    chk({31'h00000000, hresp}, 32'h0000_0000);
    $display("Test reset done");
  endtask

  // Main sequence
  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 12'h000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0000_0000;
    wake_req    = 1'b0;
    miscompares = 0;
    tests_run   = 0;
    t_reset();
    t_op(OP_SUBLIT, 8'h03, 8'h05, 3'b000, 1'b0);
    t_op(OP_SUBLIT, 8'h10, 8'h10, 3'b000, 1'b1);
    t_op(OP_SUBFILE, 8'h3A, 8'h1B, 3'b000, 1'b1);
    t_op(OP_SUBFILE, 8'h3A, 8'h1B, 3'b000, 1'b0);
    t_op(OP_SUBBORROW, 8'h10, 8'h01, 3'b000, 1'b1);
    t_op(OP_SUBBORROW, 8'h10, 8'h01, 3'b001, 1'b0);
    t_op(OP_SUBBORROW, 8'h01, 8'h00, 3'b000, 1'b0);
    t_op(OP_SWAP, 8'hA5, 8'h00, 3'b111, 1'b0);
    t_op(OP_SWAP, 8'h3C, 8'h11, 3'b010, 1'b1);
    t_op(OP_XORLIT, 8'h0F, 8'h0F, 3'b011, 1'b1);
    t_op(OP_XORFILE, 8'hC3, 8'h5A, 3'b100, 1'b1);
    t_op(OP_XORFILE, 8'h77, 8'h77, 3'b001, 1'b0);
    t_dir();
    t_sleep();
    close_out();
  end
endmodule

// file: hdl/exec_pkg.sv
// Shared constants and types for the subtract/swap/xor/sleep execution unit
package exec_pkg;

  // Register byte offsets on the AHB-Lite port
  localparam logic [11:0] OFS_CMD       = 12'h000;
  localparam logic [11:0] OFS_WORK      = 12'h004;
  localparam logic [11:0] OFS_STATUS    = 12'h008;
  localparam logic [11:0] OFS_DIR       = 12'h00C;
  localparam logic [11:0] OFS_WATCHDOG  = 12'h010;
  localparam logic [11:0] OFS_FILE_BASE = 12'h200;
  localparam logic [11:0] OFS_FILE_LAST = 12'h3FC;

  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OPND_LSB = 8;
  localparam int CMD_DEST_BIT = 16;

  // Status word fields
  localparam int ST_C_BIT          = 0;
  localparam int ST_HALF_CARRY_BIT = 1;
  localparam int ST_Z_BIT          = 2;
  localparam int ST_POWER_DOWN_BIT = 3;
  localparam int ST_EXPIRY_BIT     = 4;
  localparam int ST_SLEEP_BIT      = 5;
  localparam int ST_BUSY_BIT       = 6;

  // Reset and load values, direction port selects and file depth
  localparam logic [7:0] WORK_RST     = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'hFF;
  localparam logic [7:0] WATCHDOG_CLR = 8'h00;
  localparam logic [7:0] PORT_A_SEL   = 8'h05;
  localparam logic [7:0] PORT_B_SEL   = 8'h06;
  localparam logic [7:0] PORT_C_SEL   = 8'h07;
  localparam int         FILE_DEPTH   = 128;

  // Operation codes carried in the command word
  typedef enum logic [2:0] {
    OP_SLEEP = 3'h0, OP_SUBLIT = 3'h1, OP_SUBFILE = 3'h2, OP_SUBBORROW = 3'h3,
    OP_SWAP  = 3'h4, OP_DIR    = 3'h5, OP_XORLIT  = 3'h6, OP_XORFILE   = 3'h7
  } op_type;

  typedef struct packed {
    logic       dest;
    logic [7:0] operand;
    op_type     op;
  } cmd_type;

  typedef struct packed {
    logic expiry;
    logic power_down;
    logic z;
    logic half_carry;
    logic c;
  } flags_type;

  typedef struct packed {
    logic [7:0] port_c;
    logic [7:0] port_b;
    logic [7:0] port_a;
  } dir_type;

endpackage

// file: hdl/exec_unit.sv
// Execution unit for sleep, subtract, nibble swap, direction load and xor, with AHB-Lite access
`timescale 1ns/1ps
module exec_unit
  import exec_pkg::*;
#(
  parameter int ADDR_W  = 12,
  parameter int PRESC_W = 8
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // Core side
  input  wire logic              wake_req,
  output exec_pkg::dir_type      dir_out,
  output logic                   sleeping
);
  import exec_pkg::*;

  generate
    if (ADDR_W < 12 || PRESC_W < 1 || PRESC_W > 24) begin : g_bad_param
      $error("exec_unit parameters out of range");
    end
  endgenerate

  // Execution sequence, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC  = 3'b100
  } state_type;

  // Operations that read the file register
  function automatic logic reads_file(input op_type op);
    return (op == OP_SUBFILE) || (op == OP_SUBBORROW) || (op == OP_SWAP) || (op == OP_XORFILE);
  endfunction

  // Borrow-style subtract: a - b - !cin, with carry and digit carry as not-borrow
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] full;
    logic [4:0] half;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return {full[8], half[4], full[7:0]};
  endfunction

  state_type            state_ff, nxt_state;
  cmd_type              cmd_ff, nxt_cmd;
  flags_type            flags_ff, nxt_flags;
  dir_type              dir_ff, nxt_dir;
  logic [7:0]           work_ff, nxt_work;
  logic [7:0]           wdog_ff, nxt_wdog;
  logic [PRESC_W-1:0]   presc_ff, nxt_presc;
  logic                 sleep_ff, nxt_sleep;
  logic                 dph_ff, nxt_dph;
  logic                 dwr_ff, nxt_dwr;
  logic [ADDR_W-1:0]    daddr_ff, nxt_daddr;
  logic                 rdwait_ff, nxt_rdwait;
  logic                 busy;
  logic                 in_file;
  logic                 wr_done;
  logic [6:0]           mem_addr;
  logic                 mem_we;
  logic [7:0]           mem_wdata;
  logic [7:0]           mem_rdata;
  logic [9:0]           sub_res;
  logic [7:0]           result;
  logic                 to_file;

  assign busy    = !state_ff[0];
  assign in_file = (daddr_ff[11:0] >= OFS_FILE_BASE) && (daddr_ff[11:0] <= OFS_FILE_LAST);

  // Bus stalls while an operation runs so the memory port is never shared
  always_comb begin
    hreadyout = 1'b1;
    if (dph_ff && (busy || (!dwr_ff && in_file && !rdwait_ff))) begin
      hreadyout = 1'b0;
    end
  end
  assign hresp   = 1'b0;
  assign wr_done = dph_ff && dwr_ff && hreadyout;

  // Address phase capture and file read wait state
  always_comb begin
    nxt_dph    = dph_ff;
    nxt_dwr    = dwr_ff;
    nxt_daddr  = daddr_ff;
    nxt_rdwait = 1'b0;
    if (dph_ff && !hreadyout) begin
      nxt_rdwait = !busy;
    end
    if (hready) begin
      nxt_dph   = hsel && htrans[1];
      nxt_dwr   = hwrite;
      nxt_daddr = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff    <= 1'b0;
      dwr_ff    <= 1'b0;
      daddr_ff  <= '0;
      rdwait_ff <= 1'b0;
    end else begin
      dph_ff    <= nxt_dph;
      dwr_ff    <= nxt_dwr;
      daddr_ff  <= nxt_daddr;
      rdwait_ff <= nxt_rdwait;
    end
  end

  // Read mux; file data is the memory's registered output
  always_comb begin
    hrdata = 32'h0000_0000;
    if (in_file) begin
      hrdata[7:0] = mem_rdata;
    end else begin
      unique case (daddr_ff[11:0])
        OFS_CMD: begin
          // Fields go back to their bus positions, not the struct's packing
          hrdata[CMD_OP_LSB +: 3]   = cmd_ff.op;
          hrdata[CMD_OPND_LSB +: 8] = cmd_ff.operand;
          hrdata[CMD_DEST_BIT]      = cmd_ff.dest;
        end
        OFS_WORK:     hrdata[7:0] = work_ff;
        OFS_STATUS:   hrdata[6:0] = {busy, sleep_ff, flags_ff};
        OFS_DIR:      hrdata[23:0] = dir_ff;
        OFS_WATCHDOG: hrdata[PRESC_W+7:0] = {presc_ff, wdog_ff};
        default:      hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Arithmetic and result selection for the operation in execution
  always_comb begin
    logic [7:0] minuend;
    minuend = (cmd_ff.op == OP_SUBLIT) ? cmd_ff.operand : mem_rdata;
    sub_res = sub8(minuend, work_ff, (cmd_ff.op == OP_SUBBORROW) ? flags_ff.c : 1'b1);
    unique case (cmd_ff.op)
      OP_SWAP:    result = {mem_rdata[3:0], mem_rdata[7:4]};
      OP_XORLIT:  result = work_ff ^ cmd_ff.operand;
      OP_XORFILE: result = work_ff ^ mem_rdata;
      default:    result = sub_res[7:0];
    endcase
    to_file = reads_file(cmd_ff.op) && cmd_ff.dest;
  end

  // Memory port: execution owns it while busy, the bus otherwise
  always_comb begin
    mem_addr  = daddr_ff[8:2];
    mem_we    = wr_done && in_file;
    mem_wdata = hwdata[7:0];
    if (busy) begin
      mem_addr  = cmd_ff.operand[6:0];
      mem_we    = state_ff[2] && to_file;
      mem_wdata = result;
    end
  end

  file_ram #(
    .DEPTH (FILE_DEPTH),
    .AW    (7)
  ) u_file_ram (
    .clk      (hclk),
    .addr     (mem_addr),
    .we       (mem_we),
    .wdata    (mem_wdata),
    .rdata_ff (mem_rdata)
  );

  // Sequencer, working register, flags, direction registers and watchdog
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd   = cmd_ff;
    nxt_flags = flags_ff;
    nxt_dir   = dir_ff;
    nxt_work  = work_ff;
    nxt_sleep = sleep_ff;
    nxt_wdog  = wdog_ff;
    nxt_presc = presc_ff;
    // Watchdog only advances while the clock runs; sleep freezes it
    if (!sleep_ff) begin
      nxt_presc = presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};
      if (&presc_ff) begin
        nxt_wdog = wdog_ff + 8'h01;
      end
    end else if (wake_req) begin
      nxt_sleep = 1'b0;
    end
    // Software writes; only reachable when idle, since the bus stalls otherwise
    if (wr_done && !in_file) begin
      unique case (daddr_ff[11:0])
        OFS_CMD: begin
          // A halted core drops commands rather than queueing them
          if (!sleep_ff) begin
            nxt_cmd.op      = op_type'(hwdata[CMD_OP_LSB +: 3]);
            nxt_cmd.operand = hwdata[CMD_OPND_LSB +: 8];
            nxt_cmd.dest    = hwdata[CMD_DEST_BIT];
            nxt_state       = reads_file(op_type'(hwdata[CMD_OP_LSB +: 3])) ? ST_FETCH : ST_EXEC;
          end
        end
        OFS_WORK: nxt_work = hwdata[7:0];
        OFS_STATUS: begin
          nxt_flags.c          = hwdata[ST_C_BIT];
          nxt_flags.half_carry = hwdata[ST_HALF_CARRY_BIT];
          nxt_flags.z          = hwdata[ST_Z_BIT];
        end
        default: nxt_state = state_ff;
      endcase
    end
    unique case (state_ff)
      ST_IDLE:  nxt_state = nxt_state;
      ST_FETCH: nxt_state = ST_EXEC;
      ST_EXEC: begin
        nxt_state = ST_IDLE;
        unique case (cmd_ff.op)
          OP_SLEEP: begin
            nxt_wdog              = WATCHDOG_CLR;
            nxt_presc             = '0;
            nxt_flags.expiry      = 1'b1;
            nxt_flags.power_down  = 1'b0;
            nxt_sleep             = 1'b1;
          end
          OP_DIR: begin
            if (cmd_ff.operand == PORT_A_SEL) nxt_dir.port_a = work_ff;
            if (cmd_ff.operand == PORT_B_SEL) nxt_dir.port_b = work_ff;
            if (cmd_ff.operand == PORT_C_SEL) nxt_dir.port_c = work_ff;
          end
          OP_SWAP: begin
            if (!to_file) nxt_work = result;
          end
          OP_XORLIT, OP_XORFILE: begin
            if (!to_file) nxt_work = result;
            nxt_flags.z = (result == 8'h00);
          end
          default: begin
            if (!to_file) nxt_work = result;
            nxt_flags.c  = sub_res[9];
            nxt_flags.half_carry = sub_res[8];
            nxt_flags.z  = (result == 8'h00);
          end
        endcase
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      cmd_ff   <= '0;
      flags_ff <= 5'b11000;
      dir_ff   <= {DIR_RST, DIR_RST, DIR_RST};
      work_ff  <= WORK_RST;
      sleep_ff <= 1'b0;
      wdog_ff  <= WATCHDOG_CLR;
      presc_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff   <= nxt_cmd;
      flags_ff <= nxt_flags;
      dir_ff   <= nxt_dir;
      work_ff  <= nxt_work;
      sleep_ff <= nxt_sleep;
      wdog_ff  <= nxt_wdog;
      presc_ff <= nxt_presc;
    end
  end

  assign dir_out  = dir_ff;
  assign sleeping = sleep_ff;

  // Checks on the execution behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SLEEP_CLEARS: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_SLEEP |=>
      wdog_ff == 8'h00 && presc_ff == '0 && flags_ff.expiry && !flags_ff.power_down && sleep_ff)
    else $error("sleep did not clear watchdog or set flags");
  AST_HALTED: assert property (sleep_ff && !wake_req |=> state_ff == ST_IDLE && $stable(wdog_ff))
    else $error("core advanced while asleep");
  AST_SUBLIT: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_SUBLIT |=>
      work_ff == 8'($past(cmd_ff.operand) - $past(work_ff)) && flags_ff.z == (work_ff == 8'h00))
    else $error("literal subtract result wrong");
  AST_SUBFILE_C: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_SUBFILE |=>
      flags_ff.c == ($past(work_ff) <= $past(mem_rdata)))
    else $error("file subtract carry wrong");
  AST_BORROW: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_SUBBORROW && !cmd_ff.dest |=>
      work_ff == 8'($past(mem_rdata) - $past(work_ff) - {7'h00, !$past(flags_ff.c)}))
    else $error("borrow subtract result wrong");
  AST_SWAP_FLAGS: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_SWAP |=> $stable(flags_ff))
    else $error("swap changed a flag");
  AST_DIR_LOAD: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_DIR && cmd_ff.operand == PORT_B_SEL |=>
      dir_ff.port_b == $past(work_ff) && $stable(flags_ff) && $stable(dir_ff.port_a))
    else $error("direction load wrong");
  AST_XOR_FLAGS: assert property (state_ff == ST_EXEC && (cmd_ff.op == OP_XORLIT || cmd_ff.op == OP_XORFILE) |=>
      flags_ff.c == $past(flags_ff.c) && flags_ff.half_carry == $past(flags_ff.half_carry))
    else $error("xor changed carry flags");
  AST_XOR_DEST: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_XORFILE && cmd_ff.dest |=>
      $stable(work_ff))
    else $error("xor to file changed working register");
  AST_HALF_CARRY: assert property (state_ff == ST_EXEC && cmd_ff.op == OP_SUBLIT |=>
      flags_ff.half_carry == ($past(work_ff[3:0]) <= $past(cmd_ff.operand[3:0])))
    else $error("digit carry wrong");
  AST_OP_DONE: assert property (state_ff == ST_FETCH |=> state_ff == ST_EXEC ##1 state_ff == ST_IDLE)
    else $error("operation did not finish in two cycles");

  COV_SLEEP_WAKE: cover property (sleep_ff ##1 !sleep_ff);
  COV_SUB_BORROW: cover property (state_ff == ST_EXEC && cmd_ff.op == OP_SUBBORROW && !flags_ff.c);
  COV_FILE_WB: cover property (mem_we && busy);
  COV_STALL: cover property (!hreadyout ##1 hreadyout);

endmodule

// file: hdl/file_ram.sv
// Register file memory with a registered read port
`timescale 1ns/1ps
module file_ram #(
  parameter int DEPTH  = 128,
  parameter int AW     = 7
) (
  // Clock
  input  wire logic          clk,
  // Single access port
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_ff
);

  logic [7:0] mem [DEPTH];

  generate
    if (DEPTH > (1 << AW)) begin : g_bad_depth
      $error("file_ram depth exceeds address range");
    end
  endgenerate

  // Contents hold no reset, so no reset port is needed
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end

endmodule
